// ==== hdl/flash_ctl_pkg.sv ====
// Constants shared by the flash/torch mode controller and its serial port.
// Assumes a 20 MHz system clock; timing counts derive from it.
package flash_ctl_pkg;
   // Register indices (only the low three address bits are decoded)
   localparam logic [2:0] REG_MASTER = 3'h0;
   localparam logic [2:0] REG_FLASH  = 3'h1;
   localparam logic [2:0] REG_TORCH  = 3'h2;
   // Master control/status fields
   localparam int MASTER_ON_BIT  = 3;
   localparam int MASTER_SHT_BIT = 2;
   localparam int MASTER_OP_BIT  = 1;
   localparam int MASTER_TSD_BIT = 0;
   // Flash and torch control fields
   localparam int DUR_MSB      = 7;
   localparam int DUR_LSB      = 5;
   localparam int ENABLE_BIT   = 4;
   localparam int INHIBIT_BIT  = 5;
   localparam int LEVEL_MSB    = 3;
   localparam int LEVEL_LSB    = 0;
   // Reset values
   localparam logic       MASTER_ON_RESET = 1'b0;
   localparam logic [7:0] FLASH_RESET     = 8'hE0;
   localparam logic [7:0] TORCH_RESET     = 8'h00;
   localparam logic [7:0] READ_ZERO       = 8'h00;
   // Timing
   localparam int CLK_HZ            = 20000000;
   localparam int EN_LOW_TIME_MS    = 1000;
   localparam int EN_LOW_CYCLES     = EN_LOW_TIME_MS * (CLK_HZ / 1000);
   localparam int FLASH_STEP_US     = 156250;
   localparam int FLASH_STEP_CYCLES = FLASH_STEP_US * (CLK_HZ / 1000000);
   // Serial port
   localparam logic [6:0] DEV_ADDR  = 7'h5A;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   // Operating modes
   typedef enum logic [3:0] {
      MODE_OFF     = 4'h1,
      MODE_STANDBY = 4'h2,
      MODE_TORCH   = 4'h4,
      MODE_FLASH   = 4'h8
   } mode_t;
   // Serial port states
   typedef enum logic [6:0] {
      SP_IDLE = 7'h01,
      SP_DEV  = 7'h02,
      SP_REG  = 7'h04,
      SP_WR   = 7'h08,
      SP_ACK  = 7'h10,
      SP_RD   = 7'h20,
      SP_RACK = 7'h40
   } sport_t;
endpackage

// ==== hdl/serial_reg_port.sv ====
// Two-wire serial register port: write and read of an 8-register space.
// Assumes SCL/SDA already synchronous to clk and slow against it.
`timescale 1ns/10ps
module serial_reg_port
(
   // Clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Line
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_oe_n,
   // Register access
   output logic            wr_stb,
   output logic [2:0]      reg_ptr,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data
);
   flash_ctl_pkg::sport_t state_reg;
   logic [7:0] shift_reg;
   logic [3:0] cnt_reg;
   logic       scl_reg;
   logic       sda_reg;
   logic       rnw_reg;
   logic       after_dev_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // Line edge and framing detection
   assign scl_rise  = scl_in & ~scl_reg;
   assign scl_fall  = ~scl_in & scl_reg;
   assign start_det = scl_in & scl_reg & sda_reg & ~sda_in;
   assign stop_det  = scl_in & scl_reg & ~sda_reg & sda_in;

   // Previous line levels
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end
      else if (ce)
      begin
         scl_reg <= scl_in;
         sda_reg <= sda_in;
      end
   end

   // Byte engine; acknowledge is driven after the eighth bit falls
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg     <= flash_ctl_pkg::SP_IDLE;
         shift_reg     <= 8'h00;
         cnt_reg       <= 4'h0;
         rnw_reg       <= 1'b0;
         after_dev_reg <= 1'b0;
         sda_oe_n      <= 1'b1;
         wr_stb        <= 1'b0;
         reg_ptr       <= 3'h0;
         wr_data       <= 8'h00;
      end
      else if (ce)
      begin
         wr_stb <= 1'b0;
         if (start_det)
         begin
            state_reg <= flash_ctl_pkg::SP_DEV;
            cnt_reg   <= 4'h0;
            sda_oe_n  <= 1'b1;
         end
         else if (stop_det)
         begin
            state_reg <= flash_ctl_pkg::SP_IDLE;
            sda_oe_n  <= 1'b1;
         end
         else
         begin
            case (state_reg)
               flash_ctl_pkg::SP_DEV, flash_ctl_pkg::SP_REG, flash_ctl_pkg::SP_WR:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda_in};
                     cnt_reg   <= cnt_reg + 4'h1;
                  end
                  else if (scl_fall && cnt_reg == flash_ctl_pkg::BITS_BYTE)
                  begin
                     after_dev_reg <= (state_reg == flash_ctl_pkg::SP_DEV);
                     if (state_reg == flash_ctl_pkg::SP_DEV)
                     begin
                        if (shift_reg[7:1] == flash_ctl_pkg::DEV_ADDR)
                        begin
                           rnw_reg   <= shift_reg[0];
                           sda_oe_n  <= 1'b0;
                           state_reg <= flash_ctl_pkg::SP_ACK;
                        end
                        else
                           state_reg <= flash_ctl_pkg::SP_IDLE;
                     end
                     else
                     begin
                        if (state_reg == flash_ctl_pkg::SP_REG)
                           reg_ptr <= shift_reg[2:0];
                        else
                        begin
                           wr_data <= shift_reg;
                           wr_stb  <= 1'b1;
                        end
                        sda_oe_n  <= 1'b0;
                        state_reg <= flash_ctl_pkg::SP_ACK;
                     end
                  end
               end
               flash_ctl_pkg::SP_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_reg <= 4'h0;
                     if (rnw_reg && after_dev_reg)
                     begin
                        shift_reg <= rd_data;
                        sda_oe_n  <= rd_data[7];
                        state_reg <= flash_ctl_pkg::SP_RD;
                     end
                     else
                     begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= after_dev_reg ? flash_ctl_pkg::SP_REG : flash_ctl_pkg::SP_WR;
                     end
                  end
               end
               flash_ctl_pkg::SP_RD:
               begin
                  if (scl_rise)
                     cnt_reg <= cnt_reg + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_reg == flash_ctl_pkg::BITS_BYTE)
                     begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= flash_ctl_pkg::SP_RACK;
                     end
                     else
                     begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_n  <= shift_reg[6];
                     end
                  end
               end
               flash_ctl_pkg::SP_RACK:
               begin
                  // Master acknowledge asks for the next register
                  if (scl_rise)
                  begin
                     if (sda_in)
                        state_reg <= flash_ctl_pkg::SP_IDLE;
                     else
                     begin
                        reg_ptr       <= reg_ptr + 3'h1;
                        after_dev_reg <= 1'b1;
                        state_reg     <= flash_ctl_pkg::SP_ACK;
                     end
                  end
               end
               default:
                  state_reg <= state_reg;
            endcase
         end
      end
   end
endmodule // serial_reg_port

// ==== hdl/flash_torch_mode_control.sv ====
// Mode control of a boost flash LED driver: enables, flash timer, levels.
// Assumes all pins synchronous to CLK; the analog stage uses the level code
// and reference select to scale the resistor-set maximum current.
//
// Contract
// - Chip-enable high keeps the device in enabled standby.
// - Chip-enable low over one second shuts down; shorter lows do not.
// - Software can enable the whole chip over the serial port; clearing the on bit disables it only while chip enable is long low.
// - Torch-enable pin high starts and holds torch current.
// - Flash-enable rising edge starts flash and restarts the safety timer.
// - Inhibit high in flash drops to torch level; low restores flash level.
// - Flash runs on pin or register enable; stops when both are low.
// - Flash current is flash maximum times the flash level code.
// - Flash held past the safety timeout is switched off.
// - Inhibit also works on register-started flash.
// - Torch runs on pin or register enable; stops when both are low.
// - Torch current is torch maximum times the torch level code.
// - Overvoltage turns the device off.
// - Software on bit is ORed with the chip-enable pin but has no long-low filter; it acts at once.
// - Flash duration field selects 156.25 ms steps, 156.25 to 1250 ms.
// - Level fields give 16 steps; code 0 is 100 percent, code 1 is 90.
// - Torch register enable behaves exactly like the torch-enable pin.
`timescale 1ns/10ps
module flash_torch_mode_control
#(
   parameter int EN_LOW_CYCLES     = flash_ctl_pkg::EN_LOW_CYCLES,
   parameter int FLASH_STEP_CYCLES = flash_ctl_pkg::FLASH_STEP_CYCLES
)
(
   // Clock, reset, enable
   input  wire logic CLK,
   input  wire logic RESETN,
   input  wire logic CE,
   // Control pins
   input  wire logic CHIP_ENABLE_PIN,
   input  wire logic TORCH_ENABLE_PIN,
   input  wire logic FLASH_ENABLE_PIN,
   input  wire logic FLASH_INHIBIT_PIN,
   // Analog monitors
   input  wire logic OVERVOLTAGE_DETECT,
   input  wire logic LED_SHORT_DETECT,
   input  wire logic LED_OPEN_DETECT,
   input  wire logic THERMAL_DETECT,
   // Serial register port
   input  wire logic SCL,
   input  wire logic SDA_I,
   output logic      SDA_O,
   output logic      SDA_OE_N,
   // Current stage control
   output logic       CHIP_ACTIVE,
   output logic       FLASH_ON,
   output logic       TORCH_ON,
   output logic       REF_FLASH_MAX,
   output logic [3:0] LED_LEVEL_CODE,
   output logic       FLASH_TIMED_OUT
);
   logic       rst_sync1_reg;
   logic       rst_n;
   logic       wr_stb;
   logic [2:0] reg_ptr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       master_on_reg;
   logic [7:0] flash_control_reg;
   logic [7:0] torch_control_reg;
   logic [31:0] en_low_cnt_reg;
   logic        en_long_low;
   logic        ovp_latch_reg;
   logic        chip_on;
   logic        fen_pin_reg;
   logic        fen_bit_reg;
   logic        flash_req;
   logic        flash_start;
   logic [31:0] flash_cnt_reg;
   logic [31:0] flash_limit;
   logic        expired_reg;
   logic        torch_req;
   logic        inhibit;
   flash_ctl_pkg::mode_t mode_next;

   // Flash window length for a duration code, in clock cycles
   function automatic logic [31:0] flash_window(input logic [2:0] code);
      flash_window = (32'(code) + 32'h1) * 32'(FLASH_STEP_CYCLES);
   endfunction

   // Reset release through two stages
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_sync1_reg <= 1'b0;
         rst_n         <= 1'b0;
      end
      else
      begin
         rst_sync1_reg <= 1'b1;
         rst_n         <= rst_sync1_reg;
      end
   end

   serial_reg_port u_port
   (
      .clk      (CLK),
      .rst_n    (rst_n),
      .ce       (CE),
      .scl_in   (SCL),
      .sda_in   (SDA_I),
      .sda_oe_n (SDA_OE_N),
      .wr_stb   (wr_stb),
      .reg_ptr  (reg_ptr),
      .wr_data  (wr_data),
      .rd_data  (rd_data)
   );

   // Read mux; unused addresses read zero
   always_comb
   begin
      rd_data = flash_ctl_pkg::READ_ZERO;
      case (reg_ptr)
         flash_ctl_pkg::REG_MASTER:
         begin
            rd_data[flash_ctl_pkg::MASTER_ON_BIT]  = master_on_reg;
            rd_data[flash_ctl_pkg::MASTER_SHT_BIT] = LED_SHORT_DETECT;
            rd_data[flash_ctl_pkg::MASTER_OP_BIT]  = LED_OPEN_DETECT;
            rd_data[flash_ctl_pkg::MASTER_TSD_BIT] = THERMAL_DETECT;
         end
         flash_ctl_pkg::REG_FLASH: rd_data = flash_control_reg;
         flash_ctl_pkg::REG_TORCH: rd_data = torch_control_reg;
         default:                  rd_data = flash_ctl_pkg::READ_ZERO;
      endcase
   end

   // Register writes on each acknowledged data byte
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_on_reg     <= flash_ctl_pkg::MASTER_ON_RESET;
         flash_control_reg <= flash_ctl_pkg::FLASH_RESET;
         torch_control_reg <= flash_ctl_pkg::TORCH_RESET;
      end
      else if (CE && wr_stb)
      begin
         case (reg_ptr)
            flash_ctl_pkg::REG_MASTER: master_on_reg <= wr_data[flash_ctl_pkg::MASTER_ON_BIT];
            flash_ctl_pkg::REG_FLASH:  flash_control_reg <= wr_data;
            flash_ctl_pkg::REG_TORCH:  torch_control_reg <= wr_data;
            default:                   master_on_reg <= master_on_reg;
         endcase
      end
   end

   // Long-low filter on chip enable; saturates so it never wraps
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         en_low_cnt_reg <= 32'h0;
      else if (CE)
      begin
         if (CHIP_ENABLE_PIN)
            en_low_cnt_reg <= 32'h0;
         else if (!en_long_low)
            en_low_cnt_reg <= en_low_cnt_reg + 32'h1;
      end
   end

   assign en_long_low = (en_low_cnt_reg >= 32'(EN_LOW_CYCLES));
   // Software on bit is an alternative to the pin
   assign chip_on = (!en_long_low || master_on_reg) && !ovp_latch_reg;

   // Overvoltage latch, held until chip enable is long low and the software on bit is clear
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         ovp_latch_reg <= 1'b0;
      else if (CE)
      begin
         if (OVERVOLTAGE_DETECT)
            ovp_latch_reg <= 1'b1;
         else if (en_long_low && !master_on_reg)
            ovp_latch_reg <= 1'b0;
      end
   end

   // Flash request and start events from pin edge or register bit edge
   assign flash_req   = FLASH_ENABLE_PIN || flash_control_reg[flash_ctl_pkg::ENABLE_BIT];
   assign flash_start = (FLASH_ENABLE_PIN && !fen_pin_reg) ||
                        (flash_control_reg[flash_ctl_pkg::ENABLE_BIT] && !fen_bit_reg);
   assign flash_limit = flash_window(flash_control_reg[flash_ctl_pkg::DUR_MSB:flash_ctl_pkg::DUR_LSB]);
   assign torch_req   = TORCH_ENABLE_PIN || torch_control_reg[flash_ctl_pkg::ENABLE_BIT];
   assign inhibit     = FLASH_INHIBIT_PIN || torch_control_reg[flash_ctl_pkg::INHIBIT_BIT];

   // Safety timer, one cycle ahead of the registered output
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fen_pin_reg   <= 1'b0;
         fen_bit_reg   <= 1'b0;
         flash_cnt_reg <= 32'h0;
         expired_reg   <= 1'b0;
      end
      else if (CE)
      begin
         fen_pin_reg <= FLASH_ENABLE_PIN;
         fen_bit_reg <= flash_control_reg[flash_ctl_pkg::ENABLE_BIT];
         if (flash_start)
         begin
            flash_cnt_reg <= 32'h0;
            expired_reg   <= 1'b0;
         end
         else if (!flash_req || !chip_on)
         begin
            flash_cnt_reg <= 32'h0;
            expired_reg   <= 1'b0;
         end
         else if (!expired_reg)
         begin
            if (flash_cnt_reg + 32'h2 >= flash_limit)
               expired_reg <= 1'b1;
            flash_cnt_reg <= flash_cnt_reg + 32'h1;
         end
      end
   end

   // Mode selection; flash outranks torch
   always_comb
   begin
      if (!chip_on)
         mode_next = flash_ctl_pkg::MODE_OFF;
      else if (flash_req && !expired_reg)
         mode_next = flash_ctl_pkg::MODE_FLASH;
      else if (torch_req)
         mode_next = flash_ctl_pkg::MODE_TORCH;
      else
         mode_next = flash_ctl_pkg::MODE_STANDBY;
   end

   // Registered drive to the current stage
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         SDA_O           <= 1'b0;
         CHIP_ACTIVE     <= 1'b0;
         FLASH_ON        <= 1'b0;
         TORCH_ON        <= 1'b0;
         REF_FLASH_MAX   <= 1'b0;
         LED_LEVEL_CODE  <= 4'h0;
         FLASH_TIMED_OUT <= 1'b0;
      end
      else if (CE)
      begin
         SDA_O           <= 1'b0;
         CHIP_ACTIVE     <= (mode_next != flash_ctl_pkg::MODE_OFF);
         FLASH_TIMED_OUT <= expired_reg && flash_req;
         case (mode_next)
            flash_ctl_pkg::MODE_FLASH:
            begin
               FLASH_ON <= 1'b1;
               TORCH_ON <= 1'b0;
               if (inhibit)
               begin
                  REF_FLASH_MAX  <= 1'b0;
                  LED_LEVEL_CODE <= torch_control_reg[flash_ctl_pkg::LEVEL_MSB:flash_ctl_pkg::LEVEL_LSB];
               end
               else
               begin
                  REF_FLASH_MAX  <= 1'b1;
                  LED_LEVEL_CODE <= flash_control_reg[flash_ctl_pkg::LEVEL_MSB:flash_ctl_pkg::LEVEL_LSB];
               end
            end
            flash_ctl_pkg::MODE_TORCH:
            begin
               FLASH_ON       <= 1'b0;
               TORCH_ON       <= 1'b1;
               REF_FLASH_MAX  <= 1'b0;
               LED_LEVEL_CODE <= torch_control_reg[flash_ctl_pkg::LEVEL_MSB:flash_ctl_pkg::LEVEL_LSB];
            end
            default:
            begin
               FLASH_ON       <= 1'b0;
               TORCH_ON       <= 1'b0;
               REF_FLASH_MAX  <= 1'b0;
               LED_LEVEL_CODE <= 4'h0;
            end
         endcase
      end
   end
endmodule // flash_torch_mode_control

// ==== bench/flash_mode_monitor.sv ====
// Port checker for the flash/torch mode controller.
// Assumes it is bound to the top module with the same count parameters.
`timescale 1ns/10ps
module flash_mode_monitor
#(
   parameter int EN_LOW_CYCLES     = 50,
   parameter int FLASH_STEP_CYCLES = 20
)
(
   // Clock and reset
   input wire logic       CLK,
   input wire logic       RESETN,
   input wire logic       CE,
   // Pins
   input wire logic       CHIP_ENABLE_PIN,
   input wire logic       TORCH_ENABLE_PIN,
   input wire logic       FLASH_ENABLE_PIN,
   input wire logic       FLASH_INHIBIT_PIN,
   input wire logic       OVERVOLTAGE_DETECT,
   // Current stage
   input wire logic       CHIP_ACTIVE,
   input wire logic       FLASH_ON,
   input wire logic       TORCH_ON,
   input wire logic       REF_FLASH_MAX,
   input wire logic [3:0] LED_LEVEL_CODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   int low_cnt;
   int on_cnt;
   // Enable-low run length; advances only while the clock enable is high
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN) low_cnt <= 0;
      else if (CHIP_ENABLE_PIN) low_cnt <= 0;
      else if (CE) low_cnt <= low_cnt + 1;
   // Continuous flash length, restarted by a fresh pin edge
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN) on_cnt <= 0;
      else if (!FLASH_ON || $rose(FLASH_ENABLE_PIN)) on_cnt <= 0;
      else on_cnt <= on_cnt + 1;
   a_flash_start: assert property ($rose(FLASH_ENABLE_PIN) && CE && CHIP_ACTIVE && CHIP_ENABLE_PIN
      && !OVERVOLTAGE_DETECT |=> FLASH_ON) else $error("flash not started");
   a_inhibit_torch: assert property (FLASH_ON && $past(FLASH_INHIBIT_PIN) |-> !REF_FLASH_MAX)
      else $error("inhibit ignored");
   a_flash_limit: assert property (on_cnt <= 8 * FLASH_STEP_CYCLES + 2)
      else $error("flash too long");
   a_torch_pin: assert property ($past(TORCH_ENABLE_PIN) && $past(CE) && CHIP_ACTIVE && !FLASH_ON |-> TORCH_ON)
      else $error("torch missing");
   a_off_quiet: assert property (!CHIP_ACTIVE |-> !FLASH_ON && !TORCH_ON)
      else $error("current while off");
   a_ovp_off: assert property (OVERVOLTAGE_DETECT && CE |-> ##[1:2] !CHIP_ACTIVE)
      else $error("overvoltage ignored");
   a_short_low: assert property ($fell(CHIP_ACTIVE) |-> low_cnt >= EN_LOW_CYCLES - 2
      || $past(OVERVOLTAGE_DETECT) || $past(OVERVOLTAGE_DETECT, 2) || $past(OVERVOLTAGE_DETECT, 3))
      else $error("early shutdown");
   a_torch_ref: assert property (TORCH_ON |-> !REF_FLASH_MAX && !FLASH_ON)
      else $error("torch on flash ref");
endmodule // flash_mode_monitor

// ==== bench/host_bus_model.sv ====
// Host side of the two-wire register port: register writes only.
// Assumes the bench resolves the open-drain line and feeds it back.
`timescale 1ns/10ps
module host_bus_model
(
   // Clock and resolved line
   input  wire logic clk,
   input  wire logic sda_line,
   // Host drive, 1 means released to the pull-up
   output logic      scl = 1'b1,
   output logic      sda_rel = 1'b1,
   output int        nacks = 0
);
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Byte MSB first, then release for the device acknowledge
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         sda_rel <= b[i];
         wait_clk(2);
         scl <= 1'b1;
         wait_clk(3);
         scl <= 1'b0;
         wait_clk(1);
      end
      sda_rel <= 1'b1;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(2);
      if (sda_line !== 1'b0) nacks++;
      wait_clk(1);
      scl <= 1'b0;
      wait_clk(1);
   endtask
   // Start, address with write, register, data, stop
   task automatic write_reg(input logic [2:0] r, input logic [7:0] d);
      wait_clk(1);
      sda_rel <= 1'b0;
      wait_clk(3);
      scl <= 1'b0;
      wait_clk(1);
      send_byte({flash_ctl_pkg::DEV_ADDR, 1'b0});
      send_byte({5'h00, r});
      send_byte(d);
      sda_rel <= 1'b0;
      wait_clk(2);
      scl <= 1'b1;
      wait_clk(3);
      sda_rel <= 1'b1;
      wait_clk(3);
   endtask
endmodule // host_bus_model

// ==== bench/testbench.sv ====
// Self-checking bench for the flash/torch mode controller.
// Assumes the package, design, host model and checker compile first.
`timescale 1ns/10ps
module testbench;
   localparam int EN_LOW = 50;
   localparam int STEP   = 20;
   logic        clk;
   logic        resetn = 1'b0;
   logic        en_pin = 1'b1;
   logic        torch_enable_pin    = 1'b0;
   logic        flash_enable_pin    = 1'b0;
   logic        fi     = 1'b0;
   logic        overvoltage_shutdown    = 1'b0;
   logic        scl;
   logic        sda_rel;
   logic        sda_oe_n, sda_o;
   wire logic   sda_line = sda_rel & (sda_oe_n | sda_o);
   logic        active, flash_on, torch_on, ref_max, timed_out;
   logic [3:0]  level, flvl, tlvl;
   logic [31:0] rng = 32'h00010CB5;
   int          nacks, cyc, c0;
   int          mismatches = 0;
   int          n_tests = 0;
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) cyc++;
   flash_torch_mode_control #(.EN_LOW_CYCLES(EN_LOW), .FLASH_STEP_CYCLES(STEP)) flash_torch_mode_control_i (
      .CLK(clk), .RESETN(resetn), .CE(1'b1), .CHIP_ENABLE_PIN(en_pin), .TORCH_ENABLE_PIN(torch_enable_pin),
      .FLASH_ENABLE_PIN(flash_enable_pin), .FLASH_INHIBIT_PIN(fi), .OVERVOLTAGE_DETECT(overvoltage_shutdown), .LED_SHORT_DETECT(1'b0),
      .LED_OPEN_DETECT(1'b0), .THERMAL_DETECT(1'b0), .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o),
      .SDA_OE_N(sda_oe_n), .CHIP_ACTIVE(active), .FLASH_ON(flash_on), .TORCH_ON(torch_on),
      .REF_FLASH_MAX(ref_max), .LED_LEVEL_CODE(level), .FLASH_TIMED_OUT(timed_out));
   host_bus_model host_bus_model_i (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel), .nacks(nacks));
   function automatic logic [3:0] rnd4();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[3:0];
   endfunction
   // Safety timeout length for a duration code
   function automatic int flash_len(input logic [2:0] code);
      return (int'(code) + 1) * STEP;
   endfunction
   task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_len(input string what, input int exp, input int got);
      n_tests++;
      if (got != exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog sized well above the expected run
   initial
   begin
      #(40000 * 50);
      mismatches++;
      end_sim();
   end
   // Main sequence
   initial
   begin
      tlvl = rnd4();
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_TORCH, {4'h0, tlvl});
      torch_enable_pin <= 1'b1;
      settle(1);
      chk_val("torch on", 4'h1, torch_on);
      chk_val("torch level", tlvl, level);
      chk_val("torch ref", 4'h0, ref_max);
      @(posedge clk) torch_enable_pin <= 1'b0;
      host_bus_model_i.write_reg(3'h3, 8'hFF);
      settle(1);
      chk_val("unmapped write", 4'h0, {flash_on, torch_on});
      $display("test torch_pin finished");
      for (int d = 0; d < 8; d++)
      begin
         flvl = rnd4();
         host_bus_model_i.write_reg(flash_ctl_pkg::REG_FLASH, {d[2:0], 1'b0, flvl});
         flash_enable_pin <= 1'b1;
         settle(1);
         c0 = cyc;
         chk_val("flash on", 4'h1, flash_on);
         chk_val("flash level", flvl, level);
         chk_val("flash ref", 4'h1, ref_max);
         if (d == 5)
         begin
            @(posedge clk) fi <= 1'b1;
            settle(1);
            chk_val("inhibit level", tlvl, level);
            chk_val("inhibit ref", 4'h0, ref_max);
            @(posedge clk) fi <= 1'b0;
            settle(1);
            chk_val("restore level", flvl, level);
         end
         while (flash_on === 1'b1 && cyc - c0 < 400) @(negedge clk);
         chk_len("flash time", flash_len(d[2:0]), cyc - c0);
         chk_val("timed out", 4'h1, timed_out);
         @(posedge clk) flash_enable_pin <= 1'b0;
         settle(1);
         chk_val("timeout clear", 4'h0, timed_out);
      end
      $display("test flash_timer finished");
      @(posedge clk) fi <= 1'b1;
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_FLASH, {3'h7, 1'b1, flvl});
      settle(1);
      chk_val("reg flash on", 4'h1, flash_on);
      chk_val("reg flash inhibit", tlvl, level);
      @(posedge clk) fi <= 1'b0;
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_FLASH, {3'h7, 1'b0, flvl});
      settle(1);
      chk_val("reg flash off", 4'h0, {flash_on, timed_out});
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_TORCH, {4'h1, tlvl});
      settle(1);
      chk_val("reg torch on", 4'h1, torch_on);
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_TORCH, {4'h0, tlvl});
      settle(1);
      chk_val("reg torch off", 4'h0, torch_on);
      $display("test register_modes finished");
      @(posedge clk) en_pin <= 1'b0;
      repeat (EN_LOW - 20) @(posedge clk);
      en_pin <= 1'b1;
      settle(2);
      chk_val("short low", 4'h1, active);
      @(posedge clk) en_pin <= 1'b0;
      settle(EN_LOW + 5);
      chk_val("long low", 4'h0, active);
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_MASTER, 8'h08);
      settle(1);
      chk_val("soft on", 4'h1, active);
      host_bus_model_i.write_reg(flash_ctl_pkg::REG_MASTER, 8'h00);
      settle(1);
      chk_val("soft off", 4'h0, active);
      @(posedge clk) en_pin <= 1'b1;
      settle(2);
      chk_val("pin on", 4'h1, active);
      $display("test enable finished");
      @(posedge clk) torch_enable_pin <= 1'b1;
      @(posedge clk) overvoltage_shutdown <= 1'b1;
      @(posedge clk) overvoltage_shutdown <= 1'b0;
      settle(2);
      chk_val("overvoltage", 4'h0, {active, torch_on});
      @(posedge clk) en_pin <= 1'b0;
      torch_enable_pin <= 1'b0;
      repeat (EN_LOW + 5) @(posedge clk);
      en_pin <= 1'b1;
      settle(2);
      chk_val("recovered", 4'h1, active);
      chk_len("acknowledges", 0, nacks);
      $display("test overvoltage finished");
      end_sim();
   end
endmodule // testbench
bind flash_torch_mode_control flash_mode_monitor #(.EN_LOW_CYCLES(EN_LOW_CYCLES),
   .FLASH_STEP_CYCLES(FLASH_STEP_CYCLES)) flash_mode_monitor_i (.CLK(CLK), .RESETN(RESETN), .CE(CE),
   .CHIP_ENABLE_PIN(CHIP_ENABLE_PIN), .TORCH_ENABLE_PIN(TORCH_ENABLE_PIN), .FLASH_ENABLE_PIN(FLASH_ENABLE_PIN),
   .FLASH_INHIBIT_PIN(FLASH_INHIBIT_PIN), .OVERVOLTAGE_DETECT(OVERVOLTAGE_DETECT), .CHIP_ACTIVE(CHIP_ACTIVE),
   .FLASH_ON(FLASH_ON), .TORCH_ON(TORCH_ON), .REF_FLASH_MAX(REF_FLASH_MAX), .LED_LEVEL_CODE(LED_LEVEL_CODE));
